/* File: inc/fpg_pkg.sv */
/*
 * Package for the floppy pin gating block: register offsets, field positions,
 * reset values, base-address limits and the structs that carry pin groups.
 * Assumes a 32-bit classic Wishbone slave, byte addresses, one word per register.
 */
package fpg_pkg;
    // register byte offsets
    localparam logic [7:0] FPG_MODE_CFG_OFS = 8'h00;
    localparam logic [7:0] FPG_GLOBAL_OFS = 8'h04;
    localparam logic [7:0] FPG_RATE_OFS = 8'h08;
    localparam logic [7:0] FPG_DISABLE_OFS = 8'h0c;
    localparam logic [7:0] FPG_BASE_OFS = 8'h10;
    localparam logic [7:0] FPG_STATUS_OFS = 8'h14;
    // field positions
    localparam int FPG_OUT_CTRL_BIT = 7;
    localparam int FPG_ACTIVATE_BIT = 0;
    localparam int FPG_POWER_BIT = 0;
    localparam int FPG_AUTO_PM_BIT = 8;
    localparam int FPG_MANUAL_PD_BIT = 6;
    localparam int FPG_FORCE_BIT = 0;
    // reset values
    localparam logic [7:0] FPG_MODE_CFG_RST = 8'h00;
    localparam logic [8:0] FPG_GLOBAL_RST = 9'h001;
    localparam logic [7:0] FPG_RATE_RST = 8'h00;
    localparam logic [7:0] FPG_DISABLE_RST = 8'h00;
    localparam logic [11:0] FPG_BASE_RST = 12'h3f0;
    // exclusive limits of a valid base address
    localparam logic [11:0] FPG_BASE_LOW = 12'h100;
    localparam logic [11:0] FPG_BASE_HIGH = 12'hff8;

    // drive-interface outputs from the controller core
    typedef struct packed {
        logic write_serial_l;
        logic density_select0;
        logic head_side_l;
        logic write_gate_l;
        logic head_direction_l;
        logic head_pulse_l;
        logic drive_select0_l;
        logic drive_select1_l;
        logic motor_on0_l;
        logic motor_on1_l;
    } fpg_drive_s;

    // one pin group as driven onto the pads
    typedef struct packed {
        fpg_drive_s value;
        logic oe;
    } fpg_pins_s;
endpackage

/* File: hdl/fpg_gate.sv */
/*
 * Floppy output gating and forced write protect, with a Wishbone register file.
 * Assumes: core outputs come from logic on clk_i; write-protect and auto-power
 * inputs come from pins or other domains and are synchronised here.
 */
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
// Summary of operation
// - standard floppy outputs float when the floppy device is powered down or not activated.
// - output-control bit 7 of the mode configuration register floats the standard outputs.
// - output-control bit leaves the parallel-port outputs driven when active and powered.
// - activation bit zero or power-down floats both standard and parallel-port outputs.
// - base address valid only strictly between 0x100 and 0xff8, else outputs float.
// - global power bit 0 at zero floats the outputs.
// - manual power-down bit 6 of the data-rate register floats the outputs.
// - manual power-down wins over automatic power management.
// - with auto management on, outputs float only when every auto condition holds.
// - gated set is write data, density, head, write gate, direction, step, selects, motors.
// - force write-protect bit is D0 of the disable register, active high, reset to zero.
// - a low external write-protect always asserts internal write protect.
// - otherwise internal protect asserts only with the force bit and a drive select low.
// - the same combination serves the standard and the parallel-port write-protect inputs.
module fpg_gate (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire fpg_pkg::fpg_drive_s core_drive_i,
    input wire logic auto_pd_ok_i,
    input wire logic std_protect_l_i,
    input wire logic par_protect_l_i,
    input wire logic par_select_i,
    output fpg_pkg::fpg_pins_s std_pins_o,
    output fpg_pkg::fpg_pins_s par_pins_o,
    output logic write_protect_l_o
);
    import fpg_pkg::*;

    // registers
    logic [7:0] mode_cfg_q, mode_cfg_d;
    logic [8:0] global_q, global_d;
    logic [7:0] rate_q, rate_d;
    logic [7:0] disable_q, disable_d;
    logic [11:0] base_q, base_d;
    logic activate_q, activate_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [31:0] status_w;

    // synchronisers for off-domain levels
    logic [1:0] std_wp_s1_q, std_wp_s2_q;
    logic [1:0] apd_s_q;

    // output stage
    fpg_pins_s std_q, std_d, par_q, par_d;
    logic wp_q, wp_d;

    logic access_w, base_ok_w, powered_w, live_w, std_en_w, par_en_w;
    logic wp_in_w, sel_low_w;

    assign access_w = wb_cyc_i && wb_stb_i && !ack_q;
    assign base_ok_w = (base_q > FPG_BASE_LOW) && (base_q < FPG_BASE_HIGH);
    // manual power-down is checked first so auto management cannot undo it
    assign powered_w = global_q[FPG_POWER_BIT] && !rate_q[FPG_MANUAL_PD_BIT]
        && !(global_q[FPG_AUTO_PM_BIT] && apd_s_q[1]);
    assign live_w = activate_q && base_ok_w && powered_w;
    assign std_en_w = live_w && !mode_cfg_q[FPG_OUT_CTRL_BIT];
    assign par_en_w = live_w;
    assign status_w = {26'h0000000, base_ok_w, powered_w, live_w, std_en_w, par_en_w, wp_q};

    always_comb begin
        mode_cfg_d = mode_cfg_q;
        global_d = global_q;
        rate_d = rate_q;
        disable_d = disable_q;
        base_d = base_q;
        activate_d = activate_q;
        ack_d = access_w;
        rdat_d = 32'h00000000;
        if (access_w && wb_we_i) begin
            case (wb_adr_i[7:0])
                FPG_MODE_CFG_OFS: begin
                    if (wb_sel_i[0]) mode_cfg_d = wb_dat_i[7:0];
                    if (wb_sel_i[1]) activate_d = wb_dat_i[8 + FPG_ACTIVATE_BIT];
                end
                FPG_GLOBAL_OFS: begin
                    if (wb_sel_i[0]) global_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) global_d[8] = wb_dat_i[8];
                end
                FPG_RATE_OFS: begin
                    if (wb_sel_i[0]) rate_d = wb_dat_i[7:0];
                end
                FPG_DISABLE_OFS: begin
                    if (wb_sel_i[0]) disable_d = wb_dat_i[7:0];
                end
                FPG_BASE_OFS: begin
                    if (wb_sel_i[0]) base_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) base_d[11:8] = wb_dat_i[11:8];
                end
                default: begin
                end
            endcase
        end
        if (access_w && !wb_we_i) begin
            case (wb_adr_i[7:0])
                FPG_MODE_CFG_OFS: rdat_d = {23'h000000, activate_q, mode_cfg_q};
                FPG_GLOBAL_OFS: rdat_d = {23'h000000, global_q};
                FPG_RATE_OFS: rdat_d = {24'h000000, rate_q};
                FPG_DISABLE_OFS: rdat_d = {24'h000000, disable_q};
                FPG_BASE_OFS: rdat_d = {20'h00000, base_q};
                FPG_STATUS_OFS: rdat_d = status_w;
                default: rdat_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_cfg_q <= FPG_MODE_CFG_RST;
            global_q <= FPG_GLOBAL_RST;
            rate_q <= FPG_RATE_RST;
            disable_q <= FPG_DISABLE_RST;
            base_q <= FPG_BASE_RST;
            activate_q <= 1'b0;
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            mode_cfg_q <= mode_cfg_d;
            global_q <= global_d;
            rate_q <= rate_d;
            disable_q <= disable_d;
            base_q <= base_d;
            activate_q <= activate_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // write-protect path: the mux picks the interface in use, one rule serves both
    assign wp_in_w = par_select_i ? std_wp_s2_q[1] : std_wp_s2_q[0];
    assign sel_low_w = !core_drive_i.drive_select0_l || !core_drive_i.drive_select1_l;

    always_comb begin
        std_d.value = core_drive_i;
        std_d.oe = std_en_w;
        par_d.value = core_drive_i;
        par_d.oe = par_en_w;
        wp_d = 1'b1;
        if (!wp_in_w) begin
            wp_d = 1'b0;
        end else if (disable_q[FPG_FORCE_BIT] && sel_low_w) begin
            wp_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            std_wp_s1_q <= 2'h3;
            std_wp_s2_q <= 2'h3;
            apd_s_q <= 2'h0;
            std_q <= '0;
            par_q <= '0;
            wp_q <= 1'b1;
        end else begin
            std_wp_s1_q <= {par_protect_l_i, std_protect_l_i};
            std_wp_s2_q <= std_wp_s1_q;
            apd_s_q <= {apd_s_q[0], auto_pd_ok_i};
            std_q <= std_d;
            par_q <= par_d;
            wp_q <= wp_d;
        end
    end

    // outputs register one cycle after core or register inputs change; protect and auto-power pins take three, via the synchronisers
    assign std_pins_o = std_q;
    assign par_pins_o = par_q;
    assign write_protect_l_o = wp_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    a_std_float_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !live_w |=> !std_pins_o.oe) else $error("standard pins driven while not live");
    a_out_ctrl_std: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_cfg_q[FPG_OUT_CTRL_BIT] |=> !std_pins_o.oe) else $error("output control ignored");
    a_par_kept_on: assert property (@(posedge clk_i) disable iff (rst_i)
        live_w && mode_cfg_q[FPG_OUT_CTRL_BIT] |=> par_pins_o.oe && !std_pins_o.oe)
        else $error("parallel pins wrongly floated");
    a_both_float: assert property (@(posedge clk_i) disable iff (rst_i)
        !activate_q |=> !par_pins_o.oe && !std_pins_o.oe) else $error("pins driven while inactive");
    a_base_range: assert property (@(posedge clk_i) disable iff (rst_i)
        (base_q <= FPG_BASE_LOW || base_q >= FPG_BASE_HIGH) |=> !par_pins_o.oe)
        else $error("invalid base drives pins");
    a_power_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !global_q[FPG_POWER_BIT] |=> !par_pins_o.oe) else $error("pins driven with power off");
    a_manual_pd: assert property (@(posedge clk_i) disable iff (rst_i)
        rate_q[FPG_MANUAL_PD_BIT] |=> !par_pins_o.oe) else $error("manual power-down lost");
    a_auto_pm: assert property (@(posedge clk_i) disable iff (rst_i)
        activate_q && base_ok_w && global_q[FPG_POWER_BIT] && !rate_q[FPG_MANUAL_PD_BIT]
        && !global_q[FPG_AUTO_PM_BIT] |=> par_pins_o.oe) else $error("pins floated without cause");
    a_wp_pin_low: assert property (@(posedge clk_i) disable iff (rst_i)
        !wp_in_w |=> !write_protect_l_o) else $error("pin write protect lost");
    a_wp_forced: assert property (@(posedge clk_i) disable iff (rst_i)
        wp_in_w && !(disable_q[FPG_FORCE_BIT] && sel_low_w) |=> write_protect_l_o)
        else $error("spurious write protect");
    a_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

    // gating seen from the standard pins as well, since only they obey the output-control bit
    a_manual_pd_std: assert property (@(posedge clk_i) disable iff (rst_i)
        rate_q[FPG_MANUAL_PD_BIT] |=> !std_pins_o.oe)
        else $error("manual power-down ignored on standard pins");

    a_manual_over_auto: assert property (@(posedge clk_i) disable iff (rst_i)
        rate_q[FPG_MANUAL_PD_BIT] && global_q[FPG_AUTO_PM_BIT] && !apd_s_q[1] |=> !par_pins_o.oe)
        else $error("auto management undid manual power-down");

    a_auto_float: assert property (@(posedge clk_i) disable iff (rst_i)
        global_q[FPG_AUTO_PM_BIT] && apd_s_q[1] |=> !par_pins_o.oe && !std_pins_o.oe)
        else $error("auto power-down did not float pins");

    a_auto_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        activate_q && base_ok_w && global_q[FPG_POWER_BIT] && !rate_q[FPG_MANUAL_PD_BIT]
        && global_q[FPG_AUTO_PM_BIT] && !apd_s_q[1] |=> par_pins_o.oe)
        else $error("pins floated with auto conditions unmet");

    a_std_value: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> std_pins_o.value == $past(core_drive_i))
        else $error("standard pin values differ from core");

    a_par_value: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> par_pins_o.value == $past(core_drive_i))
        else $error("parallel pin values differ from core");

    // reset values, seen at the first edges after release
    a_force_reset: assert property (@(posedge clk_i)
        $past(rst_i) |-> !disable_q[FPG_FORCE_BIT])
        else $error("force bit not cleared by reset");

    a_wp_reset: assert property (@(posedge clk_i)
        $past(rst_i) |-> write_protect_l_o)
        else $error("write protect active after reset");

    a_oe_reset: assert property (@(posedge clk_i)
        $past(rst_i) |-> !std_pins_o.oe && !par_pins_o.oe)
        else $error("pins driven after reset");

    a_wp_par_path: assert property (@(posedge clk_i) disable iff (rst_i)
        par_select_i && !std_wp_s2_q[1] |=> !write_protect_l_o)
        else $error("parallel write protect lost");

    a_wp_std_path: assert property (@(posedge clk_i) disable iff (rst_i)
        !par_select_i && !std_wp_s2_q[0] |=> !write_protect_l_o)
        else $error("standard write protect lost");

    a_wp_force_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        wp_in_w && disable_q[FPG_FORCE_BIT] && sel_low_w |=> !write_protect_l_o)
        else $error("forced write protect missing");

    a_wp_no_force: assert property (@(posedge clk_i) disable iff (rst_i)
        wp_in_w && !disable_q[FPG_FORCE_BIT] |=> write_protect_l_o)
        else $error("write protect without force");

    a_std_live_on: assert property (@(posedge clk_i) disable iff (rst_i)
        live_w && !mode_cfg_q[FPG_OUT_CTRL_BIT] |=> std_pins_o.oe)
        else $error("standard pins floated while live");

    a_par_live_on: assert property (@(posedge clk_i) disable iff (rst_i)
        live_w |=> par_pins_o.oe)
        else $error("parallel pins floated while live");

    a_std_in_par: assert property (@(posedge clk_i) disable iff (rst_i)
        std_pins_o.oe |-> par_pins_o.oe)
        else $error("standard driven without parallel");

    a_base_std: assert property (@(posedge clk_i) disable iff (rst_i)
        (base_q <= FPG_BASE_LOW || base_q >= FPG_BASE_HIGH) |=> !std_pins_o.oe)
        else $error("invalid base drives standard pins");

    a_power_std: assert property (@(posedge clk_i) disable iff (rst_i)
        !global_q[FPG_POWER_BIT] |=> !std_pins_o.oe)
        else $error("standard pins driven with power off");

    // bus handshake: one answer per request, data zero outside the answer
    a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        access_w |=> wb_ack_o)
        else $error("request not acknowledged");

    a_read_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data outside ack");
endmodule // fpg_gate

/* File: verif/fpg_drive_model.sv */
/*
 * drive-side stand-in: a standard drive and a parallel-port drive presenting write-protect tabs.
 * assumes the bench picks each tab state; the protect lines idle high through pull-ups.
 */
module fpg_drive_model (
    input wire logic clk_i,
    input wire fpg_pkg::fpg_pins_s std_pins_i,
    input wire fpg_pkg::fpg_pins_s par_pins_i,
    input wire logic [1:0] tab_i,
    output logic std_protect_l_o,
    output logic par_protect_l_o
);
    import fpg_pkg::*;
    int selected_clks = 0;
    // the tab pulls the line low; otherwise the pull-up holds it high
    always_comb std_protect_l_o = tab_i[0];
    always_comb par_protect_l_o = tab_i[1];
    // counts cycles drive select 0 is really driven low on either pin group, handy when reading waves
    always_ff @(posedge clk_i) begin
        if ((std_pins_i.oe && !std_pins_i.value.drive_select0_l) || (par_pins_i.oe && !par_pins_i.value.drive_select0_l))
            selected_clks <= selected_clks + 1;
    end
endmodule // fpg_drive_model

/* File: verif/fpg_gate_tb.sv */
/*
 * bench for fpg_gate: random configurations with base-address corners.
 * assumes a one-cycle wishbone ack and registered gating outputs.
 */
module fpg_gate_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fpg_pkg::*;
    `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end
    logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o, write_protect_l_o;
    logic auto_pd_ok_i = 0, par_select_i = 0, std_protect_l_i, par_protect_l_i;
    logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = '0;
    logic [1:0] wp_cmd = 2'h3;
    fpg_drive_s core_drive_i = '0;
    fpg_pins_s std_pins_o, par_pins_o;
    logic act, oc, pwr, aut, mpd, frc, lv;
    logic [11:0] base;
    int n_mismatch = 0, num_checks = 0;
    logic [11:0] corners [6] = '{12'h100, 12'h101, 12'hff7, 12'hff8, 12'h000, 12'hfff};
    always #12.5 clk_i = ~clk_i;

    fpg_gate dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .core_drive_i(core_drive_i), .auto_pd_ok_i(auto_pd_ok_i), .std_protect_l_i(std_protect_l_i),
        .par_protect_l_i(par_protect_l_i), .par_select_i(par_select_i), .std_pins_o(std_pins_o),
        .par_pins_o(par_pins_o), .write_protect_l_o(write_protect_l_o));
    fpg_drive_model drive (.clk_i(clk_i), .std_pins_i(std_pins_o), .par_pins_i(par_pins_o), .tab_i(wp_cmd),
        .std_protect_l_o(std_protect_l_i), .par_protect_l_o(par_protect_l_i));

    task report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // request held until the rising edge that samples ack, data taken and request released there
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_adr_i <= {24'h0, a};
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    function automatic logic wp_f(fpg_drive_s c);
        logic ext;
        ext = par_select_i ? wp_cmd[1] : wp_cmd[0];
        return ext && !(frc && (!c.drive_select0_l || !c.drive_select1_l));
    endfunction

    initial begin
        void'($urandom(32'hea4d));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(FPG_BASE_OFS, 1'b0, 32'h0);
        `CHK("base_rst", 32'h3f0, rd)
        `CHK("rst_oe", 1'b0, std_pins_o.oe)
        `CHK("force_rst", 1'b1, write_protect_l_o)
        wb(8'h40, 1'b1, 32'hffff_ffff);
        wb(8'h40, 1'b0, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        for (int i = 0; i < 200; i++) begin
            {act, oc, pwr, aut, mpd, frc} = 6'($urandom);
            base = (i < 6) ? corners[i] : ((i % 2 == 0) ? 12'h3f0 : 12'($urandom));
            // bias towards live settings so the driven cases are reached often
            if (i < 6 || i % 3 == 1)
                {act, pwr, mpd} = 3'b110;
            auto_pd_ok_i <= 1'($urandom);
            par_select_i <= 1'($urandom);
            wp_cmd <= 2'($urandom);
            core_drive_i <= fpg_drive_s'($urandom);
            wb(FPG_MODE_CFG_OFS, 1'b1, {23'h0, act, oc, 6'h0, act});
            wb(FPG_GLOBAL_OFS, 1'b1, {23'h0, aut, 7'h0, pwr});
            wb(FPG_RATE_OFS, 1'b1, {25'h0, mpd, 6'h0});
            wb(FPG_DISABLE_OFS, 1'b1, {31'h0, frc});
            wb(FPG_BASE_OFS, 1'b1, {20'h0, base});
            repeat (5) @(posedge clk_i);
            @(negedge clk_i);
            lv = act && pwr && !mpd && !(aut && auto_pd_ok_i) && base > FPG_BASE_LOW && base < FPG_BASE_HIGH;
            `CHK("std_oe", lv && !oc, std_pins_o.oe)
            `CHK("par_oe", lv, par_pins_o.oe)
            if (lv)
                `CHK("std_val", core_drive_i, std_pins_o.value)
            `CHK("par_val", core_drive_i, par_pins_o.value)
            `CHK("wp", wp_f(core_drive_i), write_protect_l_o)
            wb(FPG_STATUS_OFS, 1'b0, 32'h0);
            `CHK("status", {26'h0, base > FPG_BASE_LOW && base < FPG_BASE_HIGH, pwr && !mpd && !(aut && auto_pd_ok_i), lv, lv && !oc, lv, wp_f(core_drive_i)}, rd)
        end
        report_and_stop();
    end
endmodule // fpg_gate_tb
